// ### core/flash_write_protect_config.sv
`timescale 1ns/1ps
`include "prot_cfg_consts.svh"
module flash_write_protect_config import prot_cfg_pkg::*; #(
   parameter int OTP_PAGES = `OTP_PAGES,
   parameter int PAGE_BYTES = `OTP_PAGE_BYTES,
   parameter int AW = 15
) (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic spi_clk,
   input wire logic spi_cs_n,
   input wire logic spi_mosi,
   input wire logic wp_n_pin,
   output logic spi_miso,
   output logic spi_miso_oe,
   output logic quad_enable,
   output logic wp_dedicated,
   output logic array_write_allowed,
   input wire logic otp_rd_req,
   input wire logic otp_prog_req,
   input wire logic otp_erase_req,
   input wire logic [AW-1:0] otp_addr,
   input wire logic [7:0] otp_wdata,
   output logic [7:0] otp_rdata,
   output logic otp_done,
   output logic otp_refused
);
   localparam int OTP_BYTES = OTP_PAGES * PAGE_BYTES;

   logic [3:0] meta_ff;
   logic [3:0] sync_ff;
   logic sclk_prev_ff;
   logic [7:0] prot_ff;
   logic [7:0] conf_ff;
   logic [7:0] shift_in_ff;
   logic [2:0] bit_cnt_ff;
   logic [7:0] tx_ff;
   frame_state_t state_ff;
   logic miso_ff;
   logic miso_oe_ff;
   logic quad_en_ff;
   logic wp_ded_ff;
   logic arr_wr_ff;
   logic [7:0] otp_rdata_ff;
   logic otp_done_ff;
   logic otp_refused_ff;
   logic [7:0] otp_mem [0:OTP_BYTES-1];

   logic sclk_s, cs_n_s, mosi_s, wp_s;
   logic sclk_rise, sclk_fall, byte_done;
   logic [7:0] byte_in;
   logic [1:0] srp;
   logic hw_lock, prot_wr_ok;
   logic wr_stb, wr_prot_stb, wr_conf_stb, rst_cmd_stb;
   logic otp_in_range, otp_prog_ok;
   logic [7:0] rd_sel;

   // Pin and link clock synchronisers
   always_ff @(posedge core_clk) begin
      meta_ff <= {spi_clk, spi_cs_n, spi_mosi, wp_n_pin};
      sync_ff <= meta_ff;
      sclk_prev_ff <= sync_ff[3];
   end

   assign sclk_s = sync_ff[3];
   assign cs_n_s = sync_ff[2];
   assign mosi_s = sync_ff[1];
   assign wp_s = sync_ff[0];
   assign sclk_rise = sclk_s & ~sclk_prev_ff & ~cs_n_s;
   assign sclk_fall = ~sclk_s & sclk_prev_ff & ~cs_n_s;
   assign byte_in = {shift_in_ff[6:0], mosi_s};
   assign byte_done = sclk_rise && (bit_cnt_ff == 3'h7);

   assign srp = {prot_ff[`PR_SRP_HIGH], prot_ff[`PR_SRP_LOW]};
   assign hw_lock = prot_ff[`PR_HW_EN] & ~wp_s;
   assign prot_wr_ok = ~conf_ff[`CR_PROT_LOCK]
      & (srp != 2'b10)
      & ~hw_lock
      & ~((srp == 2'b01) & ~prot_ff[`PR_HW_EN] & ~wp_s);

   assign wr_stb = byte_done && (state_ff == ST_WDATA);
   assign wr_prot_stb = wr_stb && (tx_ff == `ADDR_PROT);
   assign wr_conf_stb = wr_stb && (tx_ff == `ADDR_CONF);
   assign rst_cmd_stb = byte_done && (state_ff == ST_CMD) && (byte_in == `CMD_DEV_RESET);

   always_comb begin
      case (byte_in)
         `ADDR_PROT: rd_sel = prot_ff;
         `ADDR_CONF: rd_sel = conf_ff;
         default: rd_sel = 8'h00;
      endcase
   end

   // Frame sequencer; address byte is parked in tx_ff for writes
   always_ff @(posedge core_clk) begin
      if (reset || cs_n_s) begin
         state_ff <= ST_CMD;
         bit_cnt_ff <= 3'h0;
         shift_in_ff <= 8'h00;
         tx_ff <= 8'h00;
      end else begin
         if (sclk_rise) begin
            shift_in_ff <= byte_in;
            bit_cnt_ff <= bit_cnt_ff + 3'h1;
         end
         if (sclk_fall && state_ff == ST_RDATA) begin
            tx_ff <= {tx_ff[6:0], tx_ff[7]};
         end
         if (byte_done) begin
            case (state_ff)
               ST_CMD: begin
                  if (byte_in == `CMD_RD_STATUS) begin
                     state_ff <= ST_RADDR;
                  end else if (byte_in == `CMD_WR_STATUS) begin
                     state_ff <= ST_WADDR;
                  end else begin
                     state_ff <= ST_IGNORE;
                  end
               end
               ST_RADDR: begin
                  tx_ff <= rd_sel;
                  state_ff <= ST_RDATA;
               end
               ST_WADDR: begin
                  tx_ff <= byte_in;
                  state_ff <= ST_WDATA;
               end
               ST_WDATA: state_ff <= ST_IGNORE;
               ST_RDATA: state_ff <= ST_RDATA;
               ST_IGNORE: state_ff <= ST_IGNORE;
               default: state_ff <= ST_IGNORE;
            endcase
         end
      end
   end

   // Serial output on falling link clock edges
   always_ff @(posedge core_clk) begin
      if (reset || cs_n_s) begin
         miso_ff <= 1'b0;
         miso_oe_ff <= 1'b0;
      end else if (sclk_fall && state_ff == ST_RDATA) begin
         miso_ff <= tx_ff[7];
         miso_oe_ff <= 1'b1;
      end
   end

   // Protection register
   always_ff @(posedge core_clk) begin
      if (reset) begin
         prot_ff <= `PROT_RESET;
      end else if (wr_prot_stb && prot_wr_ok) begin
         prot_ff <= byte_in;
      end
   end

   // Configuration register
   always_ff @(posedge core_clk) begin
      if (reset) begin
         conf_ff <= `CONF_RESET;
      end else begin
         if (wr_conf_stb && !hw_lock) begin
            conf_ff[`CR_OTP_LOCK] <= conf_ff[`CR_OTP_LOCK] | byte_in[`CR_OTP_LOCK];
            conf_ff[`CR_OTP_MODE] <= byte_in[`CR_OTP_MODE];
            conf_ff[`CR_PROT_LOCK] <= conf_ff[`CR_PROT_LOCK] | (byte_in[`CR_PROT_LOCK]
               & (srp == 2'b11) & conf_ff[`CR_OTP_MODE]);
            conf_ff[`CR_ECC_EN:`CR_PAUSE_DIS] <= byte_in[`CR_ECC_EN:`CR_PAUSE_DIS];
         end
         if (rst_cmd_stb) begin
            conf_ff[`CR_OTP_MODE] <= 1'b0;
         end
      end
   end

   // Pin role and write gate
   always_ff @(posedge core_clk) begin
      if (reset) begin
         quad_en_ff <= 1'b1;
         wp_ded_ff <= 1'b0;
         arr_wr_ff <= 1'b1;
      end else begin
         quad_en_ff <= ~prot_ff[`PR_HW_EN];
         wp_ded_ff <= prot_ff[`PR_HW_EN];
         arr_wr_ff <= ~hw_lock;
      end
   end

   // One-time area
   assign otp_in_range = ({{(32 - AW) {1'b0}}, otp_addr} < OTP_BYTES);
   assign otp_prog_ok = otp_prog_req && otp_in_range && conf_ff[`CR_OTP_MODE]
      && !conf_ff[`CR_OTP_LOCK] && !hw_lock;

   initial begin
      for (int i = 0; i < OTP_BYTES; i++) begin
         otp_mem[i] = `OTP_ERASED;
      end
   end

   always_ff @(posedge core_clk) begin
      if (otp_prog_ok) begin
         otp_mem[otp_addr] <= otp_mem[otp_addr] & otp_wdata;
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         otp_rdata_ff <= 8'h00;
         otp_done_ff <= 1'b0;
         otp_refused_ff <= 1'b0;
      end else begin
         otp_done_ff <= 1'b0;
         otp_refused_ff <= 1'b0;
         if (otp_erase_req) begin
            otp_refused_ff <= 1'b1;
         end else if (otp_prog_req) begin
            otp_done_ff <= otp_prog_ok;
            otp_refused_ff <= ~otp_prog_ok;
         end else if (otp_rd_req) begin
            if (conf_ff[`CR_OTP_MODE] && otp_in_range) begin
               otp_rdata_ff <= otp_mem[otp_addr];
               otp_done_ff <= 1'b1;
            end else begin
               otp_refused_ff <= 1'b1;
            end
         end
      end
   end

   assign spi_miso = miso_ff;
   assign spi_miso_oe = miso_oe_ff;
   assign quad_enable = quad_en_ff;
   assign wp_dedicated = wp_ded_ff;
   assign array_write_allowed = arr_wr_ff;
   assign otp_rdata = otp_rdata_ff;
   assign otp_done = otp_done_ff;
   assign otp_refused = otp_refused_ff;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (reset);

   AST_QUAD_ON: assert property (!prot_ff[`PR_HW_EN] |=> quad_enable && !wp_dedicated)
      else $error("quad not enabled without hardware protection");
   AST_QUAD_OFF: assert property (prot_ff[`PR_HW_EN] |=> !quad_enable && wp_dedicated)
      else $error("quad left enabled under hardware protection");
   AST_WP_LOW_REFUSE: assert property ((srp == 2'b01) && !prot_ff[`PR_HW_EN] && !wp_s |=> $stable(prot_ff))
      else $error("protection register changed with pin low");
   AST_WP_HIGH_ACCEPT: assert property (wr_prot_stb && (srp == 2'b01) && !prot_ff[`PR_HW_EN] && wp_s
      && !conf_ff[`CR_PROT_LOCK] |=> prot_ff == $past(byte_in))
      else $error("protection write lost with pin high");
   AST_LOCKDOWN: assert property (srp == 2'b10 |=> $stable(prot_ff))
      else $error("protection register changed in lock-down");
   AST_HW_BLOCK: assert property (hw_lock && !rst_cmd_stb |=> $stable(prot_ff) && $stable(conf_ff)
      && !array_write_allowed)
      else $error("write passed under hardware block");
   AST_OTP_ERASE: assert property (otp_erase_req |=> otp_refused && !otp_done)
      else $error("erase of one-time area not refused");
   AST_OTP_LOCKED: assert property (otp_prog_req && !otp_erase_req && conf_ff[`CR_OTP_LOCK]
      |=> otp_refused && !otp_done)
      else $error("program accepted after one-time lock");
   AST_OTP_MODE: assert property ((otp_rd_req || otp_prog_req) && !conf_ff[`CR_OTP_MODE] |=> otp_refused)
      else $error("one-time area reached outside access mode");
   AST_RST_CMD: assert property (rst_cmd_stb |=> !conf_ff[`CR_OTP_MODE])
      else $error("reset command left access mode set");
   AST_FREEZE: assert property (conf_ff[`CR_PROT_LOCK] |=> $stable(prot_ff) && conf_ff[`CR_PROT_LOCK])
      else $error("frozen protection register changed");
   AST_LOCK_GUARD: assert property ($rose(conf_ff[`CR_PROT_LOCK]) |-> $past(srp == 2'b11)
      && $past(conf_ff[`CR_OTP_MODE]))
      else $error("register lock set outside allowed state");
   AST_SRP_FREE: assert property (wr_prot_stb && (srp == 2'b00) && !prot_ff[`PR_HW_EN]
      && !conf_ff[`CR_PROT_LOCK] |=> prot_ff == $past(byte_in))
      else $error("protection write refused with bits 0,0");
endmodule : flash_write_protect_config

// ### core/prot_cfg_consts.svh
`ifndef PROT_CFG_CONSTS_SVH
`define PROT_CFG_CONSTS_SVH
`define CMD_RD_STATUS 8'h05
`define CMD_WR_STATUS 8'h01
`define CMD_DEV_RESET 8'hff
`define ADDR_PROT 8'ha0
`define ADDR_CONF 8'hb0
`define ADDR_STAT 8'hc0
`define PR_SRP_LOW 7
`define PR_SRP_HIGH 0
`define PR_HW_EN 1
`define CR_OTP_LOCK 7
`define CR_OTP_MODE 6
`define CR_PROT_LOCK 5
`define CR_ECC_EN 4
`define CR_BUF_MODE 3
`define CR_DRIVE_HIGH 2
`define CR_DRIVE_LOW 1
`define CR_PAUSE_DIS 0
`define PROT_RESET 8'h7c
`define CONF_RESET 8'h18
`define OTP_PAGES 10
`define OTP_PAGE_BYTES 2176
`define OTP_ERASED 8'hff
`endif

// ### core/prot_cfg_pkg.sv
package prot_cfg_pkg;
   typedef enum logic [2:0] {ST_CMD, ST_RADDR, ST_RDATA, ST_WADDR, ST_WDATA, ST_IGNORE} frame_state_t;
endpackage : prot_cfg_pkg

// ### test/spi_host_model.sv
`timescale 1ns/1ps
module spi_host_model (
   output logic spi_clk,
   output logic spi_cs_n,
   output logic spi_mosi,
   input wire logic spi_miso,
   input wire logic spi_miso_oe
);
   // Output enable seen at the last sampled bit of a frame
   logic oe_seen;

   initial begin
      spi_clk = 1'b0;
      spi_cs_n = 1'b1;
      spi_mosi = 1'b0;
      oe_seen = 1'b0;
   end

   // Command, register address, then one data byte out or in; mode 0
   task automatic frame(input logic [23:0] tx, output logic [7:0] rx);
      rx = 8'h00;
      #167 spi_cs_n = 1'b0;
      for (int i = 23; i >= 0; i--) begin
         spi_mosi = tx[i];
         #160 spi_clk = 1'b1;
         // Sample late in the high phase, device output lags the fall
         #159 rx = {rx[6:0], spi_miso};
         oe_seen = spi_miso_oe;
         #1 spi_clk = 1'b0;
      end
      #320 spi_cs_n = 1'b1;
      // Released data line must not keep its last level
      spi_mosi = ~spi_mosi;
   endtask : frame
endmodule : spi_host_model

// ### test/tb_top.sv
`timescale 1ns/1ps
`include "prot_cfg_consts.svh"
module tb_top;
   typedef struct packed {logic wp; logic [7:0] a; logic [7:0] d; logic [7:0] exp; logic quad; logic awa;} row_t;
   logic core_clk = 1'b0;
   logic reset = 1'b1;
   logic wp_n_pin = 1'b1;
   logic [2:0] req = 3'b000;
   logic [14:0] otp_addr = 15'h0000;
   logic [7:0] otp_wdata = 8'h00;
   logic spi_clk, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe;
   logic quad_enable, wp_dedicated, array_write_allowed, otp_done, otp_refused;
   logic [7:0] otp_rdata;
   int n_fail = 0;
   int check_count = 0;
   row_t rows [10] = '{
      {1'b0, 8'ha0, 8'h78, 8'h78, 1'b1, 1'b1},
      {1'b0, 8'ha0, 8'hf8, 8'hf8, 1'b1, 1'b1},
      {1'b0, 8'ha0, 8'hf4, 8'hf8, 1'b1, 1'b1},
      {1'b1, 8'ha0, 8'hf4, 8'hf4, 1'b1, 1'b1},
      {1'b1, 8'ha0, 8'h86, 8'h86, 1'b0, 1'b1},
      {1'b0, 8'ha0, 8'h84, 8'h86, 1'b0, 1'b0},
      {1'b0, 8'hb0, 8'h58, 8'h18, 1'b0, 1'b0},
      {1'b1, 8'hb0, 8'h58, 8'h58, 1'b0, 1'b1},
      {1'b1, 8'ha0, 8'h01, 8'h01, 1'b1, 1'b1},
      {1'b1, 8'ha0, 8'h7c, 8'h01, 1'b1, 1'b1}
   };

   spi_host_model host (
      .spi_clk(spi_clk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso),
      .spi_miso_oe(spi_miso_oe)
   );

   flash_write_protect_config DUT (
      .core_clk(core_clk), .reset(reset), .spi_clk(spi_clk), .spi_cs_n(spi_cs_n),
      .spi_mosi(spi_mosi), .wp_n_pin(wp_n_pin), .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe),
      .quad_enable(quad_enable), .wp_dedicated(wp_dedicated), .array_write_allowed(array_write_allowed),
      .otp_rd_req(req[0]), .otp_prog_req(req[1]), .otp_erase_req(req[2]), .otp_addr(otp_addr),
      .otp_wdata(otp_wdata), .otp_rdata(otp_rdata), .otp_done(otp_done), .otp_refused(otp_refused)
   );

   initial forever #20 core_clk = ~core_clk;

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : report_and_stop

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] r;
      host.frame({`CMD_WR_STATUS, a, d}, r);
      repeat (4) @(posedge core_clk);
   endtask : wr

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] r;
      host.frame({`CMD_RD_STATUS, a, 8'h00}, r);
      repeat (4) @(posedge core_clk);
      check(r, exp);
      check({7'h00, host.oe_seen}, 8'h01);
      check({7'h00, spi_miso_oe}, 8'h00);
   endtask : rd_chk

   // Reset command is a frame of its own, command byte then two zero bytes that are ignored
   task automatic dev_reset();
      logic [7:0] r;
      host.frame({`CMD_DEV_RESET, 16'h0000}, r);
      repeat (4) @(posedge core_clk);
   endtask : dev_reset

   // Kind bits: erase, program, read
   task automatic otp(input logic [2:0] kind, input logic [14:0] a, input logic [7:0] d,
                      input logic [1:0] resp, input logic [7:0] exp);
      @(posedge core_clk);
      req <= kind;
      otp_addr <= a;
      otp_wdata <= d;
      @(posedge core_clk);
      req <= 3'b000;
      #1 check({6'h00, otp_done, otp_refused}, {6'h00, resp});
      if (kind == 3'b001 && resp == 2'b10) check(otp_rdata, exp);
   endtask : otp

   initial begin
      repeat (100000) @(posedge core_clk);
      n_fail++;
      report_and_stop();
   end

   initial begin
      repeat (5) @(posedge core_clk);
      reset <= 1'b0;
      foreach (rows[i]) begin
         @(posedge core_clk);
         wp_n_pin <= rows[i].wp;
         repeat (6) @(posedge core_clk);
         wr(rows[i].a, rows[i].d);
         rd_chk(rows[i].a, rows[i].exp);
         check({7'h00, quad_enable}, {7'h00, rows[i].quad});
         check({6'h00, wp_dedicated, array_write_allowed}, {6'h00, ~rows[i].quad, rows[i].awa});
      end
      @(posedge core_clk);
      reset <= 1'b1;
      repeat (3) @(posedge core_clk);
      reset <= 1'b0;
      rd_chk(`ADDR_PROT, 8'h7c);
      rd_chk(`ADDR_CONF, 8'h18);
      wr(`ADDR_PROT, 8'h81);
      wr(`ADDR_CONF, 8'h20);
      rd_chk(`ADDR_CONF, 8'h00);
      wr(`ADDR_CONF, 8'h40);
      wr(`ADDR_CONF, 8'h60);
      rd_chk(`ADDR_CONF, 8'h60);
      wr(`ADDR_PROT, 8'h7c);
      rd_chk(`ADDR_PROT, 8'h81);
      rd_chk(`ADDR_STAT, 8'h00);
      otp(3'b001, 15'h0000, 8'h00, 2'b10, 8'hff);
      otp(3'b001, 15'h54ff, 8'h00, 2'b10, 8'hff);
      otp(3'b010, 15'h0000, 8'h5a, 2'b10, 8'h00);
      otp(3'b001, 15'h0000, 8'h00, 2'b10, 8'h5a);
      otp(3'b010, 15'h0000, 8'hf0, 2'b10, 8'h00);
      otp(3'b100, 15'h0000, 8'h00, 2'b01, 8'h00);
      otp(3'b001, 15'h0000, 8'h00, 2'b10, 8'h50);
      wr(`ADDR_CONF, 8'he0);
      rd_chk(`ADDR_CONF, 8'he0);
      otp(3'b010, 15'h0001, 8'h00, 2'b01, 8'h00);
      otp(3'b001, 15'h0001, 8'h00, 2'b10, 8'hff);
      dev_reset();
      rd_chk(`ADDR_CONF, 8'ha0);
      otp(3'b001, 15'h0000, 8'h00, 2'b01, 8'h00);
      report_and_stop();
   end
endmodule : tb_top
